// *** logic/dram_ctl.sv ***
// Host-side controller driving an asynchronous multiplexed-address DRAM
module dram_ctl #(
   parameter int  POWERUP_CYCLES  = dram_ctl_pkg::POWERUP_CYC,
   parameter int  SELF_HOLD_CYCLES = dram_ctl_pkg::SELF_ENTRY_CYC,
   parameter int  BACKUP_CYCLES   = dram_ctl_pkg::BACKUP_CYC,
   parameter int  REFRESH_CYCLES  = dram_ctl_pkg::REFRESH_INTERVAL_CYC,
   parameter int  ROWS            = dram_ctl_pkg::ROW_COUNT,
   parameter bit  SLOW_GRADE      = 1'b0
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    resetn,
   // User request
   input  wire logic                    req_valid,
   input  wire dram_ctl_pkg::user_req_t req,
   output logic                         req_ready,
   output logic                         rdata_valid,
   output logic [7:0]                   rdata,
   // Modes
   input  wire logic                    self_refresh_req,
   input  wire logic                    backup_mode,
   output logic                         init_done,
   output logic                         in_self_refresh,
   // DRAM pins
   output dram_ctl_pkg::dram_pins_t     pins,
   input  wire logic [7:0]              data_lines_in,
   output logic [7:0]                   data_lines_out,
   output logic                         data_lines_oe
);

   localparam int ROW_LOW_CYC  = dram_ctl_pkg::ns_cyc(SLOW_GRADE ? dram_ctl_pkg::ROW_LOW_NS_SLOW
                                                                 : dram_ctl_pkg::ROW_LOW_NS_FAST);
   localparam int ROW_PRE_CYC  = dram_ctl_pkg::ns_cyc(SLOW_GRADE ? dram_ctl_pkg::ROW_PRE_NS_SLOW
                                                                 : dram_ctl_pkg::ROW_PRE_NS_FAST);
   localparam int COL_LOW_CYC  = dram_ctl_pkg::ns_cyc(SLOW_GRADE ? dram_ctl_pkg::COL_LOW_NS_SLOW
                                                                 : dram_ctl_pkg::COL_LOW_NS_FAST);
   localparam int CYCLE_CYC    = dram_ctl_pkg::ns_cyc(SLOW_GRADE ? dram_ctl_pkg::CYCLE_NS_SLOW
                                                                 : dram_ctl_pkg::CYCLE_NS_FAST);
   localparam int PAGE_CYC     = dram_ctl_pkg::ns_cyc(SLOW_GRADE ? dram_ctl_pkg::PAGE_CYCLE_NS_SLOW
                                                                 : dram_ctl_pkg::PAGE_CYCLE_NS_FAST);
   // Column precharge stretched so low plus high meets the page cycle
   localparam int COL_HI_CYC   = (PAGE_CYC - COL_LOW_CYC > dram_ctl_pkg::COL_PRE_CYC) ?
                                 PAGE_CYC - COL_LOW_CYC : dram_ctl_pkg::COL_PRE_CYC;
   // Row high so that low plus high meets the random cycle
   localparam int PRE_CYC      = (CYCLE_CYC - ROW_LOW_CYC > ROW_PRE_CYC) ? CYCLE_CYC - ROW_LOW_CYC : ROW_PRE_CYC;
   localparam int ROW_HOLD_CYC = 2;
   localparam int TW           = 32;

   // Two-flop synchronisers for asynchronous inputs
   logic [7:0] dq_s1_r, dq_s2_r;
   logic [1:0] mode_s1_r, mode_s2_r;

   always_ff @(posedge clk_sys) begin
      dq_s1_r   <= data_lines_in;
      dq_s2_r   <= dq_s1_r;
      mode_s1_r <= {self_refresh_req, backup_mode};
      mode_s2_r <= mode_s1_r;
   end

   dram_ctl_pkg::state_t   state_r, state_nxt;
   dram_ctl_pkg::kind_t    kind_r, kind_nxt;
   dram_ctl_pkg::dram_pins_t pins_r, pins_nxt;
   dram_ctl_pkg::user_req_t  cur_r, cur_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic [TW-1:0] rowt_r, rowt_nxt;
   logic [TW-1:0] ref_tmr_r, ref_tmr_nxt;
   logic [12:0]   burst_r, burst_nxt;
   logic [11:0]   ref_row_r, ref_row_nxt;
   logic          ref_due_r, ref_due_nxt;
   logic          init_r, init_nxt;
   logic          self_r, self_nxt;
   logic          rdy_r, rdy_nxt;
   logic          rv_r, rv_nxt;
   logic [7:0]    rd_r, rd_nxt;
   logic [7:0]    wd_r, wd_nxt;
   logic          oe_r, oe_nxt;

   function automatic logic [TW-1:0] cyc(input int n);
      return TW'(n);
   endfunction : cyc

   always_comb begin
      state_nxt   = state_r;
      kind_nxt    = kind_r;
      pins_nxt    = pins_r;
      cur_nxt     = cur_r;
      tmr_nxt     = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
      rowt_nxt    = rowt_r + 1'b1;
      ref_tmr_nxt = (ref_tmr_r != '0) ? ref_tmr_r - 1'b1 : ref_tmr_r;
      ref_due_nxt = ref_due_r | (ref_tmr_r == '0);
      burst_nxt   = burst_r;
      ref_row_nxt = ref_row_r;
      init_nxt    = init_r;
      self_nxt    = self_r;
      rdy_nxt     = 1'b0;
      rv_nxt      = 1'b0;
      rd_nxt      = rd_r;
      wd_nxt      = wd_r;
      oe_nxt      = oe_r;
      if (ref_tmr_r == '0) begin
         ref_tmr_nxt = mode_s2_r[0] ? cyc(BACKUP_CYCLES - 1) : cyc(REFRESH_CYCLES - 1);
      end
      case (state_r)
         dram_ctl_pkg::ST_POWERUP: begin
            if (tmr_r == '0) begin
               burst_nxt = 13'(dram_ctl_pkg::INIT_CYCLES);
               kind_nxt  = dram_ctl_pkg::KIND_RAS_ONLY;
               state_nxt = dram_ctl_pkg::ST_PRE;
               tmr_nxt   = '0;
            end
         end
         dram_ctl_pkg::ST_IDLE: begin
            if (burst_r != '0 || ref_due_r) begin
               if (burst_r == '0) begin
                  ref_due_nxt = (ref_tmr_r == '0);
               end else begin
                  burst_nxt = burst_r - 1'b1;
               end
               if (init_r) begin
                  kind_nxt                 = dram_ctl_pkg::KIND_CBR;
                  pins_nxt.col_strobe_n    = 1'b0;
                  state_nxt                = dram_ctl_pkg::ST_CBR_SET;
                  tmr_nxt                  = cyc(dram_ctl_pkg::CBR_SETUP_CYC - 1);
               end else begin
                  kind_nxt                 = dram_ctl_pkg::KIND_RAS_ONLY;
                  pins_nxt.multiplexed_address = ref_row_r;
                  ref_row_nxt              = ref_row_r + 1'b1;
                  state_nxt                = dram_ctl_pkg::ST_CBR_SET;
                  tmr_nxt                  = '0;
               end
            end else if (mode_s2_r[1] && !mode_s2_r[0]) begin
               kind_nxt              = dram_ctl_pkg::KIND_CBR;
               pins_nxt.col_strobe_n = 1'b0;
               self_nxt              = 1'b1;
               state_nxt             = dram_ctl_pkg::ST_CBR_SET;
               tmr_nxt               = cyc(dram_ctl_pkg::CBR_SETUP_CYC - 1);
            end else if (req_valid && !mode_s2_r[0]) begin
               cur_nxt                      = req;
               kind_nxt                     = dram_ctl_pkg::KIND_ACCESS;
               pins_nxt.multiplexed_address = req.row;
               state_nxt                    = dram_ctl_pkg::ST_CBR_SET;
               tmr_nxt                      = '0;
            end
         end
         dram_ctl_pkg::ST_CBR_SET: begin
            if (tmr_r == '0) begin
               pins_nxt.row_strobe_n = 1'b0;
               rowt_nxt              = '0;
               state_nxt             = (kind_r == dram_ctl_pkg::KIND_CBR && self_r) ? dram_ctl_pkg::ST_SELF
                                                                                     : dram_ctl_pkg::ST_ROW;
               tmr_nxt = (kind_r == dram_ctl_pkg::KIND_CBR && self_r) ? cyc(SELF_HOLD_CYCLES - 1)
                       : cyc(ROW_HOLD_CYC - 1);
            end
         end
         dram_ctl_pkg::ST_ROW: begin
            if (tmr_r == '0) begin
               if (kind_r == dram_ctl_pkg::KIND_ACCESS) begin
                  pins_nxt.multiplexed_address = {3'h0, cur_r.col};
                  pins_nxt.write_en_n          = ~cur_r.write;
                  pins_nxt.out_en_n            = cur_r.write;
                  oe_nxt                       = cur_r.write;
                  wd_nxt                       = cur_r.wdata;
                  pins_nxt.col_strobe_n        = 1'b0;
                  state_nxt                    = dram_ctl_pkg::ST_COL;
                  tmr_nxt                      = cyc(COL_LOW_CYC - 1);
               end else begin
                  state_nxt = dram_ctl_pkg::ST_ROW_END;
               end
            end
         end
         dram_ctl_pkg::ST_COL: begin
            if (tmr_r == '0) begin
               if (!cur_r.write) begin
                  rd_nxt = dq_s2_r;
                  rv_nxt = 1'b1;
               end
               pins_nxt.col_strobe_n = 1'b1;
               pins_nxt.write_en_n   = 1'b1;
               pins_nxt.out_en_n     = 1'b1;
               oe_nxt                = 1'b0;
               rdy_nxt               = 1'b1;
               state_nxt             = dram_ctl_pkg::ST_COL_PRE;
               tmr_nxt               = cyc(COL_HI_CYC - 1);
            end
         end
         dram_ctl_pkg::ST_COL_PRE: begin
            // Page continuation only while the row stays well inside the non-page limit
            if (tmr_r == '0) begin
               if (cur_r.page_more && req_valid && req.row == cur_r.row && !ref_due_r
                   && rowt_r < cyc(1000)) begin
                  cur_nxt                      = req;
                  pins_nxt.multiplexed_address = {3'h0, req.col};
                  pins_nxt.write_en_n          = ~req.write;
                  pins_nxt.out_en_n            = req.write;
                  oe_nxt                       = req.write;
                  wd_nxt                       = req.wdata;
                  pins_nxt.col_strobe_n        = 1'b0;
                  state_nxt                    = dram_ctl_pkg::ST_COL;
                  tmr_nxt                      = cyc(COL_LOW_CYC - 1);
               end else begin
                  state_nxt = dram_ctl_pkg::ST_ROW_END;
               end
            end
         end
         dram_ctl_pkg::ST_ROW_END: begin
            // Row low ends once its minimum is met; a page burst can already have held it past 1 us, up to about 1000 cycles
            if (rowt_r >= cyc(ROW_LOW_CYC - 1) || rowt_r >= cyc(dram_ctl_pkg::BACKUP_LOW_CYC)) begin
               pins_nxt.row_strobe_n = 1'b1;
               pins_nxt.col_strobe_n = 1'b1;
               state_nxt             = dram_ctl_pkg::ST_PRE;
               tmr_nxt               = cyc(PRE_CYC - 1);
            end
         end
         dram_ctl_pkg::ST_PRE: begin
            if (tmr_r == '0) begin
               if (!init_r && burst_r == '0) begin
                  init_nxt = 1'b1;
               end
               state_nxt = dram_ctl_pkg::ST_IDLE;
            end
         end
         dram_ctl_pkg::ST_SELF: begin
            if (tmr_r == '0 && !mode_s2_r[1]) begin
               pins_nxt.row_strobe_n = 1'b1;
               pins_nxt.col_strobe_n = 1'b1;
               state_nxt             = dram_ctl_pkg::ST_EXIT;
               tmr_nxt               = cyc(dram_ctl_pkg::EXIT_HOLD_CYC - 1);
            end
         end
         dram_ctl_pkg::ST_EXIT: begin
            if (tmr_r == '0) begin
               self_nxt  = 1'b0;
               burst_nxt = 13'(ROWS);
               state_nxt = dram_ctl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = dram_ctl_pkg::ST_POWERUP;
         end
      endcase
      if (state_nxt == dram_ctl_pkg::ST_IDLE && init_nxt && burst_nxt == '0 && !ref_due_nxt && !self_nxt) begin
         rdy_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_r   <= dram_ctl_pkg::ST_POWERUP;
         kind_r    <= dram_ctl_pkg::KIND_RAS_ONLY;
         pins_r    <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_en_n: 1'b1, out_en_n: 1'b1,
                        multiplexed_address: dram_ctl_pkg::ROW_RESET};
         cur_r     <= '0;
         tmr_r     <= cyc(POWERUP_CYCLES - 1);
         rowt_r    <= '0;
         ref_tmr_r <= cyc(REFRESH_CYCLES - 1);
         burst_r   <= '0;
         ref_row_r <= dram_ctl_pkg::ROW_RESET;
         ref_due_r <= 1'b0;
         init_r    <= 1'b0;
         self_r    <= 1'b0;
         rdy_r     <= 1'b0;
         rv_r      <= 1'b0;
         rd_r      <= 8'h00;
         wd_r      <= 8'h00;
         oe_r      <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         kind_r    <= kind_nxt;
         pins_r    <= pins_nxt;
         cur_r     <= cur_nxt;
         tmr_r     <= tmr_nxt;
         rowt_r    <= rowt_nxt;
         ref_tmr_r <= ref_tmr_nxt;
         burst_r   <= burst_nxt;
         ref_row_r <= ref_row_nxt;
         ref_due_r <= ref_due_nxt;
         init_r    <= init_nxt;
         self_r    <= self_nxt;
         rdy_r     <= rdy_nxt;
         rv_r      <= rv_nxt;
         rd_r      <= rd_nxt;
         wd_r      <= wd_nxt;
         oe_r      <= oe_nxt;
      end
   end

   assign pins            = pins_r;
   assign req_ready       = rdy_r;
   assign rdata_valid     = rv_r;
   assign rdata           = rd_r;
   assign init_done       = init_r;
   assign in_self_refresh = self_r;
   assign data_lines_out  = wd_r;
   assign data_lines_oe   = oe_r;

endmodule : dram_ctl

// *** logic/dram_ctl_pkg.sv ***
// Package with timing constants, states and carrier types for the DRAM controller
package dram_ctl_pkg;

   localparam int CLK_PERIOD_PS = 5000;

   // Times in their own units, converted to cycles rounding least times up
   localparam int POWERUP_PAUSE_US   = 200;
   localparam int SELF_ENTRY_HOLD_US = 100;
   localparam int BACKUP_PERIOD_US   = 125;
   localparam int BACKUP_ROW_LOW_NS  = 1000;
   localparam int REFRESH_WINDOW_MS  = 64;
   localparam int INIT_CYCLES        = 8;
   localparam int ROW_COUNT          = 4096;

   localparam int ROW_LOW_NS_FAST      = 70;
   localparam int ROW_LOW_NS_SLOW      = 80;
   localparam int ROW_PRE_NS_FAST      = 50;
   localparam int ROW_PRE_NS_SLOW      = 60;
   localparam int COL_LOW_NS_FAST      = 18;
   localparam int COL_LOW_NS_SLOW      = 20;
   localparam int COL_PRE_NS           = 10;
   localparam int CYCLE_NS_FAST        = 130;
   localparam int CYCLE_NS_SLOW        = 150;
   localparam int PAGE_CYCLE_NS_FAST   = 45;
   localparam int PAGE_CYCLE_NS_SLOW   = 50;
   localparam int CBR_SETUP_NS         = 10;
   localparam int CBR_HOLD_NS          = 20;
   localparam int SELF_EXIT_HOLD_NS    = 130;

   localparam int POWERUP_CYC    = (POWERUP_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SELF_ENTRY_CYC = (SELF_ENTRY_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BACKUP_CYC     = (BACKUP_PERIOD_US * 1000000) / CLK_PERIOD_PS;
   localparam int BACKUP_LOW_CYC = (BACKUP_ROW_LOW_NS * 1000) / CLK_PERIOD_PS - 1;
   localparam int REFRESH_INTERVAL_CYC = (REFRESH_WINDOW_MS * 1000000 / ROW_COUNT * 1000) / CLK_PERIOD_PS;

   function automatic int ns_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_cyc

   localparam int COL_PRE_CYC   = ns_cyc(COL_PRE_NS);
   localparam int CBR_SETUP_CYC = ns_cyc(CBR_SETUP_NS);
   localparam int CBR_HOLD_CYC  = ns_cyc(CBR_HOLD_NS);
   localparam int EXIT_HOLD_CYC = ns_cyc(SELF_EXIT_HOLD_NS);

   localparam logic [11:0] ROW_RESET = 12'h000;

   typedef enum logic [10:0] {
      ST_POWERUP  = 11'h001,
      ST_INIT     = 11'h002,
      ST_IDLE     = 11'h004,
      ST_ROW      = 11'h008,
      ST_COL      = 11'h010,
      ST_COL_PRE  = 11'h020,
      ST_ROW_END  = 11'h040,
      ST_PRE      = 11'h080,
      ST_CBR_SET  = 11'h100,
      ST_SELF     = 11'h200,
      ST_EXIT     = 11'h400
   } state_t;

   typedef enum logic [2:0] {
      KIND_RAS_ONLY = 3'h1,
      KIND_ACCESS   = 3'h2,
      KIND_CBR      = 3'h4
   } kind_t;

   // Strobes and enables as they leave toward the DRAM, all active low
   typedef struct packed {
      logic        row_strobe_n;
      logic        col_strobe_n;
      logic        write_en_n;
      logic        out_en_n;
      logic [11:0] multiplexed_address;
   } dram_pins_t;

   // User request: one access, page continuation flag and data
   typedef struct packed {
      logic        write;
      logic        page_more;
      logic [11:0] row;
      logic [8:0]  col;
      logic [7:0]  wdata;
   } user_req_t;

endpackage : dram_ctl_pkg

// *** testbench/dram_ctl_assertions.sv ***
// Strobe timing checks at the controller's DRAM pins
module dram_ctl_checker #(
   parameter int POWERUP_CYCLES   = 50,
   parameter int SELF_HOLD_CYCLES = 30
) (
   // Clock and reset
   input wire logic                     clk_sys,
   input wire logic                     resetn,
   // Modes
   input wire logic                     backup_mode,
   input wire logic                     init_done,
   input wire logic                     in_self_refresh,
   // DRAM pins
   input wire dram_ctl_pkg::dram_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Fast grade at a 5 ns clock, least times rounded up
   localparam int ROW_LOW_MIN = 14;
   localparam int ROW_PRE_MIN = 10;
   localparam int COL_LOW_MIN = 4;
   localparam int COL_PRE_MIN = 2;
   localparam int CYCLE_MIN   = 26;
   localparam int PAGE_MIN    = 9;
   localparam int EXIT_MIN    = 26;
   localparam int ROW_LOW_MAX = 2000;
   localparam int BACKUP_MAX  = 200;
   logic [15:0] row_lvl, col_lvl, row_per, col_per, up_cnt, falls;
   logic        row_q, col_q, was_self;
   always_ff @(posedge clk_sys) begin
      row_q    <= pins.row_strobe_n;
      col_q    <= pins.col_strobe_n;
      row_lvl  <= !resetn ? 16'h0000 : (pins.row_strobe_n != row_q) ? 16'h0001 : row_lvl + 16'(row_lvl != 16'hffff);
      col_lvl  <= !resetn ? 16'h0000 : (pins.col_strobe_n != col_q) ? 16'h0001 : col_lvl + 16'(col_lvl != 16'hffff);
      row_per  <= !resetn ? 16'h0000 : (row_q && !pins.row_strobe_n) ? 16'h0001 : row_per + 16'(row_per != 16'hffff);
      col_per  <= !resetn ? 16'h0000 : (col_q && !pins.col_strobe_n) ? 16'h0001 : col_per + 16'(col_per != 16'hffff);
      up_cnt   <= !resetn ? 16'h0000 : up_cnt + 16'(up_cnt != 16'hffff);
      falls    <= !resetn ? 16'h0000 : falls + 16'(row_q && !pins.row_strobe_n);
      was_self <= !resetn ? 1'b0 : (in_self_refresh && !pins.row_strobe_n) ? 1'b1 : (row_q && !pins.row_strobe_n) ? 1'b0
                  : was_self;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_COL_FIRST: assert property ($fell(pins.row_strobe_n) && !pins.col_strobe_n |-> !$past(pins.col_strobe_n))
      else $error("column strobe did not lead the row strobe");
   AST_SELF_HOLD: assert property ($rose(pins.row_strobe_n) && in_self_refresh |-> row_lvl >= SELF_HOLD_CYCLES)
      else $error("self refresh strobes released too early");
   AST_EXIT_HOLD: assert property ($fell(pins.row_strobe_n) && was_self |-> row_lvl >= EXIT_MIN)
      else $error("new cycle too soon after self refresh exit");
   AST_PAUSE: assert property ($fell(pins.row_strobe_n) && !init_done |-> up_cnt >= POWERUP_CYCLES)
      else $error("row strobe before power-up pause ended");
   AST_INIT_ROWS: assert property ($rose(init_done) |-> falls >= 8)
      else $error("init done before eight row cycles");
   AST_BACKUP_LOW: assert property ($rose(pins.row_strobe_n) && backup_mode |-> row_lvl < BACKUP_MAX)
      else $error("backup row low too long");
   AST_CYCLE: assert property ($fell(pins.row_strobe_n) |-> row_per >= CYCLE_MIN)
      else $error("row cycles too close");
   AST_PAGE: assert property ($fell(pins.col_strobe_n) && !pins.row_strobe_n && row_lvl > col_per |-> col_per >= PAGE_MIN)
      else $error("page column cycles too close");
   AST_ROW_LOW: assert property ($rose(pins.row_strobe_n) |-> row_lvl >= ROW_LOW_MIN)
      else $error("row low pulse too short");
   AST_ROW_MAX: assert property (!pins.row_strobe_n && !in_self_refresh |-> row_lvl <= ROW_LOW_MAX)
      else $error("row low pulse too long");
   AST_COL_LOW: assert property ($rose(pins.col_strobe_n) |-> col_lvl >= COL_LOW_MIN)
      else $error("column low pulse too short");
   AST_COL_PRE: assert property ($fell(pins.col_strobe_n) |-> col_lvl >= COL_PRE_MIN)
      else $error("column precharge too short");
   AST_ROW_PRE: assert property ($fell(pins.row_strobe_n) |-> row_lvl >= ROW_PRE_MIN)
      else $error("row precharge too short");
   C_SELF: cover property ($rose(in_self_refresh));
   C_INIT: cover property ($rose(init_done));
   C_PAGE: cover property ($fell(pins.col_strobe_n) && !pins.row_strobe_n && row_lvl > col_per);
endmodule : dram_ctl_checker

bind dram_ctl dram_ctl_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .SELF_HOLD_CYCLES(SELF_HOLD_CYCLES)) i_dram_ctl_checker (
   .clk_sys(clk_sys), .resetn(resetn), .backup_mode(backup_mode), .init_done(init_done),
   .in_self_refresh(in_self_refresh), .pins(pins));

// *** testbench/dram_model.sv ***
// Behavioural DRAM seen from its pins
module dram_model (
   // Pins from the controller
   input wire dram_ctl_pkg::dram_pins_t pins,
   input wire logic [7:0]               data_lines_out,
   input wire logic                     data_lines_oe,
   // Data toward the controller
   output logic [7:0]                   data_lines_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:255];
   logic [11:0] row_q, refresh_row = 12'h000;
   logic [8:0]  col_q;
   logic        prev_row = 1'b1, prev_col = 1'b1, col_first = 1'b0;
   int          row_falls = 0, col_first_falls = 0;
   initial data_lines_in = 8'h00;
   // Internal oscillator steps the refresh row while held in self refresh
   always #500 if (col_first && !pins.row_strobe_n) refresh_row = refresh_row + 12'h001;
   always @(pins or data_lines_oe or data_lines_out) begin
      if (prev_row && !pins.row_strobe_n) begin
         row_falls++;
         col_first = !pins.col_strobe_n;
         if (col_first) begin
            col_first_falls++;
            refresh_row = refresh_row + 12'h001;
         end else
            row_q = pins.multiplexed_address;
      end
      if (prev_col && !pins.col_strobe_n && !pins.row_strobe_n) col_q = pins.multiplexed_address[8:0];
      // Capture at the later of the column strobe and write enable falling
      if (!pins.row_strobe_n && !col_first && !pins.col_strobe_n && !pins.write_en_n && data_lines_oe)
         mem[{row_q[3:0], col_q[3:0]}] = data_lines_out;
      if (!pins.row_strobe_n && !pins.col_strobe_n && !pins.out_en_n && pins.write_en_n && !col_first)
         data_lines_in = mem[{row_q[3:0], col_q[3:0]}];
      else
         data_lines_in = ~data_lines_in;
      prev_row = pins.row_strobe_n;
      prev_col = pins.col_strobe_n;
   end
endmodule : dram_model

// *** testbench/test_dram_ctl.sv ***
// Self-checking bench for the DRAM controller against the pin-level model
module test_dram_ctl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PUP = 50, HOLD = 30, BKP = 60, REF = 200, NROW = 16;
   typedef struct packed {logic w; logic [11:0] r; logic [8:0] c; logic [7:0] d;} row_t;
   logic                     clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, self_refresh_req = 1'b0, backup_mode = 1'b0;
   dram_ctl_pkg::user_req_t  req = '0;
   dram_ctl_pkg::dram_pins_t pins;
   logic                     req_ready, rdata_valid, init_done, in_self_refresh, data_lines_oe;
   logic [7:0]               rdata, data_lines_in, data_lines_out, q;
   int                       n_mismatch = 0, n_checks = 0, base, n;
   row_t rows [8] = '{'{1'b1, 12'hfff, 9'h1ff, 8'ha5}, '{1'b1, 12'h000, 9'h000, 8'h3c}, '{1'b1, 12'ha5c, 9'h15a, 8'hc3},
      '{1'b1, 12'h5a3, 9'h0a5, 8'h7e}, '{1'b0, 12'hfff, 9'h1ff, 8'ha5}, '{1'b0, 12'h000, 9'h000, 8'h3c},
      '{1'b0, 12'ha5c, 9'h15a, 8'hc3}, '{1'b0, 12'h5a3, 9'h0a5, 8'h7e}};
   always #2.5 clk_sys = ~clk_sys;
   dram_ctl #(.POWERUP_CYCLES(PUP), .SELF_HOLD_CYCLES(HOLD), .BACKUP_CYCLES(BKP), .REFRESH_CYCLES(REF), .ROWS(NROW))
   i_dram_ctl (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rdata_valid(rdata_valid), .rdata(rdata), .self_refresh_req(self_refresh_req), .backup_mode(backup_mode),
      .init_done(init_done), .in_self_refresh(in_self_refresh), .pins(pins), .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
   dram_model i_dram_model (.pins(pins), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .data_lines_in(data_lines_in));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic give_up(input logic ok, input string what);
      if (!ok) begin
         n_mismatch++;
         $display("FAIL %s expected done seen timeout", what);
         finish_test();
      end
   endtask : give_up
   task automatic wait_for(ref logic s, input logic v, input int lim, input string what);
      int k;
      k = 0;
      while (s !== v && k < lim) begin
         @(posedge clk_sys);
         k++;
      end
      give_up(s === v, what);
   endtask : wait_for
   task automatic access(input logic w, pg, input logic [11:0] r, input logic [8:0] c, input logic [7:0] d,
                         output logic [7:0] rd);
      int k;
      k = 0;
      rd = 8'hxx;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{write: w, page_more: pg, row: r, col: c, wdata: d};
      do begin
         @(posedge clk_sys);
         k++;
         if (rdata_valid === 1'b1) rd = rdata;
      end while (!(req_ready === 1'b1 && pins.row_strobe_n === 1'b0) && k < 3000);
      if (!pg) req_valid <= 1'b0;
      give_up(k < 3000, "access");
   endtask : access
   task automatic reset_and_init();
      resetn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check("strobes in reset", 3'b110, {pins.row_strobe_n, pins.col_strobe_n, req_ready});
      resetn <= 1'b1;
      n = i_dram_model.row_falls;
      wait_for(init_done, 1'b1, 2000, "init_done");
      check("row cycles before init", 1, i_dram_model.row_falls - n >= 8);
      $display("test reset_init done");
   endtask : reset_and_init
   initial begin
      reset_and_init();
      foreach (rows[i]) begin
         access(rows[i].w, 1'b0, rows[i].r, rows[i].c, rows[i].d, q);
         check("row address", rows[i].r, i_dram_model.row_q);
         check("column address", rows[i].c, i_dram_model.col_q);
         if (!rows[i].w) check("read data", rows[i].d, q);
      end
      $display("test table done");
      // Start the page burst right after a refresh so none interrupts it
      base = i_dram_model.col_first_falls;
      for (n = 0; n < 2 * REF && i_dram_model.col_first_falls == base; n++) @(posedge clk_sys);
      n = i_dram_model.row_falls - i_dram_model.col_first_falls;
      access(1'b1, 1'b1, 12'h123, 9'h004, 8'h11, q);
      access(1'b1, 1'b0, 12'h123, 9'h005, 8'h22, q);
      check("page keeps row low", n + 1, i_dram_model.row_falls - i_dram_model.col_first_falls);
      access(1'b0, 1'b0, 12'h123, 9'h005, 8'h00, q);
      check("page data", 8'h22, q);
      $display("test page done");
      self_refresh_req <= 1'b1;
      wait_for(in_self_refresh, 1'b1, 200, "self refresh entry");
      repeat (HOLD + 20) @(posedge clk_sys);
      check("strobes low in self refresh", 2'b00, {pins.row_strobe_n, pins.col_strobe_n});
      base = i_dram_model.col_first_falls;
      self_refresh_req <= 1'b0;
      wait_for(in_self_refresh, 1'b0, 500, "self refresh exit");
      access(1'b0, 1'b0, 12'hfff, 9'h1ff, 8'h00, q);
      check("burst refresh before access", 1, i_dram_model.col_first_falls - base >= NROW);
      check("data after self refresh", 8'ha5, q);
      $display("test self_refresh done");
      backup_mode <= 1'b1;
      repeat (REF + 10) @(posedge clk_sys);
      base = i_dram_model.col_first_falls;
      n = i_dram_model.row_falls;
      req_valid <= 1'b1;
      req <= '{write: 1'b0, page_more: 1'b0, row: 12'ha5c, col: 9'h15a, wdata: 8'h00};
      repeat (BKP * 4) @(posedge clk_sys);
      check("only column-first in backup", i_dram_model.col_first_falls - base, i_dram_model.row_falls - n);
      check("backup refresh rate", 1, (i_dram_model.col_first_falls - base) inside {[3:5]});
      backup_mode <= 1'b0;
      repeat (2) @(posedge clk_sys);
      access(1'b0, 1'b0, 12'ha5c, 9'h15a, 8'h00, q);
      check("data after backup", 8'hc3, q);
      $display("test backup done");
      base = i_dram_model.col_first_falls;
      repeat (2 * REF + 50) @(posedge clk_sys);
      check("periodic refresh", 1, i_dram_model.col_first_falls - base >= 2);
      $display("test refresh done");
      reset_and_init();
      finish_test();
   end
endmodule : test_dram_ctl
